// >>> sarseq_top.v
// Function
// - At most one of four analog inputs reaches the comparator, chosen by the two-bit channel field.
// - Setting the start bit launches a conversion on the selected channel.
// - Each conversion begins by loading the approximation register with the mid-scale value.
// - One channel gives a 10-bit result, the approximation register updated from the comparator per bit.
// - At completion the end-of-conversion bit is set and the result goes to the high/low result pair.
// - After storing a result the sequencer idles until the next start request.
// - Each conversion overwrites the result registers, so software reads them before starting again.
// - A conversion is ten set-up conversion clocks then four conversion clocks per result bit.
// - The conversion clock is the system clock divided by a ratio chosen by the clock-select field.
// - Reset clears the start bit so nothing converts after reset.
// - A pin reaches the converter only when its alternate function is enabled, else it stays plain I/O.
// - The trial level for the most significant bit is half of full scale.
`include "sarseq_consts.vh"

module sarseq_top (
    // Clock and reset.
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave.
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata_ff,
    output reg hreadyout_ff,
    output reg hresp_ff,
    // Comparator and resistor-string converter.
    input wire comp_above,
    output wire [9:0] dac_code,
    // Analog input multiplexer.
    output wire [1:0] ain_sel,
    output wire [3:0] ain_connect,
    // Status and interrupt.
    output reg conv_busy_ff,
    output reg irq_ff
);

// Sequencer states.
localparam ST_IDLE = 2'h0;
localparam ST_SETUP = 2'h1;
localparam ST_BITS = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// Declarations.

// Bus pipeline.
reg [7:0] ap_addr_ff;
reg wr_pend_ff;
reg rd_pend_ff;
wire take;
reg [31:0] rd_mux;

// Software-visible state.
reg [1:0] chan_ff;
reg [1:0] clksel_ff;
reg start_ff;
reg eoc_ff;
reg [9:0] result_ff;
reg irq_stat_ff;
reg irq_mask_ff;
reg nxt_start;
reg nxt_eoc;
reg nxt_irq_stat;
reg nxt_irq_mask;
reg [3:0] port_alt_ff;

// Sequencer.
reg [1:0] state_ff;
reg [11:0] sar_ff;
reg [3:0] setup_cnt_ff;
reg [2:0] step_ff;
reg [3:0] bit_idx_ff;
reg [11:0] sar_keep;
reg [11:0] nxt_trial;
wire tick;
wire launch;
wire step_last;
wire setup_last;
wire done;

// Write strobes.
wire wr_ctrl;
wire wr_stat;
wire wr_mask;
wire wr_alt;

////////////////////////////////////////////////////////////////////////////////
// Bus address phase and write decode.

// Only haddr[7:0] is decoded, so the register set repeats every 256 bytes.
// Transfer size is not decoded: every register is one aligned word.
// Address phase is taken on a selected non-idle transfer with hready high.
assign take = hsel && htrans[1] && hready;

// Writes complete in their data phase, one cycle after the address phase.
assign wr_ctrl = wr_pend_ff && (ap_addr_ff == `SARSEQ_OFF_CTRL);
assign wr_stat = wr_pend_ff && (ap_addr_ff == `SARSEQ_OFF_IRQ_STAT);
assign wr_mask = wr_pend_ff && (ap_addr_ff == `SARSEQ_OFF_IRQ_MASK);
assign wr_alt = wr_pend_ff && (ap_addr_ff == `SARSEQ_OFF_PORT_ALT);

// The response stays OKAY: unmapped offsets read as zero and ignore writes instead of raising an error.
// Transfer pipeline; reads insert one wait state so they see every earlier write.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ap_addr_ff <= 8'h00;
        wr_pend_ff <= 1'b0;
        rd_pend_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
        hrdata_ff <= 32'h0000_0000;
        hresp_ff <= 1'b0;
    end else begin
        hresp_ff <= 1'b0;
        if (take) begin
            ap_addr_ff <= haddr[7:0];
            wr_pend_ff <= hwrite;
            rd_pend_ff <= !hwrite;
            hreadyout_ff <= hwrite;
        end else begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            if (rd_pend_ff) begin
                hreadyout_ff <= 1'b1;
            end
        end
        if (rd_pend_ff) begin
            hrdata_ff <= rd_mux;
        end
    end
end

// Read multiplexer; unmapped offsets read as zero.
always @* begin
    case (ap_addr_ff)
        `SARSEQ_OFF_CTRL: rd_mux = {26'h0, chan_ff, eoc_ff, clksel_ff, start_ff};
        `SARSEQ_OFF_RES_HIGH: rd_mux = {24'h0, result_ff[9:2]};
        `SARSEQ_OFF_RES_LOW: rd_mux = {30'h0, result_ff[1:0]};
        `SARSEQ_OFF_IRQ_STAT: rd_mux = {31'h0, irq_stat_ff};
        `SARSEQ_OFF_IRQ_MASK: rd_mux = {31'h0, irq_mask_ff};
        `SARSEQ_OFF_PORT_ALT: rd_mux = {28'h0, port_alt_ff};
        default: rd_mux = 32'h0000_0000;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// Control register.

// A conversion starts from idle once the start bit is set.
assign launch = (state_ff == ST_IDLE) && start_ff;

// Next start and end-of-conversion flags; a completion wins over a start written in the same cycle.
always @* begin
    nxt_start = start_ff;
    nxt_eoc = eoc_ff;
    if (done) begin
        nxt_start = 1'b0;
        nxt_eoc = 1'b1;
    end else begin
        if (wr_ctrl && hwdata[`SARSEQ_CTRL_START]) begin
            nxt_start = 1'b1;
        end
        if (launch) begin
            nxt_eoc = 1'b0;
        end
    end
end

// Channel and clock select follow writes at any time, even while a conversion runs.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        chan_ff <= `SARSEQ_RST_CHAN;
        clksel_ff <= `SARSEQ_RST_CLKSEL;
        start_ff <= 1'b0;
        eoc_ff <= 1'b0;
    end else begin
        if (wr_ctrl) begin
            chan_ff <= hwdata[`SARSEQ_CTRL_CHAN_HI:`SARSEQ_CTRL_CHAN_LO];
            clksel_ff <= hwdata[`SARSEQ_CTRL_CLKSEL_HI:`SARSEQ_CTRL_CLKSEL_LO];
        end
        start_ff <= nxt_start;
        eoc_ff <= nxt_eoc;
    end
end

// Alternate-function enables for the four analog pins.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        port_alt_ff <= `SARSEQ_RST_PORT_ALT;
    end else if (wr_alt) begin
        port_alt_ff <= hwdata[3:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Conversion clock and input routing.

// Divider restarts at launch so the set-up phase spans whole conversion clocks.
sarseq_clkdiv u_clkdiv (
    .hclk(hclk),
    .hresetn(hresetn),
    .clksel(clksel_ff),
    .restart(launch),
    .tick(tick)
);

// Registered analog multiplexer controls.
sarseq_chsel u_chsel (
    .hclk(hclk),
    .hresetn(hresetn),
    .chan(chan_ff),
    .port_alt(port_alt_ff),
    .ain_sel_ff(ain_sel),
    .ain_connect_ff(ain_connect)
);

////////////////////////////////////////////////////////////////////////////////
// Successive approximation sequencer.

// Last conversion clock of the set-up phase and of each bit.
assign setup_last = tick && (setup_cnt_ff == (`SARSEQ_SETUP_CLKS - 4'd1));
assign step_last = tick && (step_ff == (`SARSEQ_BIT_CLKS - 3'd1));
assign done = (state_ff == ST_BITS) && step_last && (bit_idx_ff == 4'd0);

// Bits 1:0 of the approximation register are never trial bits; they only keep its 12-bit mid-scale form.
// Keep or drop the trial bit from the comparator, then raise the next lower trial bit.
always @* begin
    sar_keep = sar_ff;
    sar_keep[bit_idx_ff + 4'd2] = comp_above;
    nxt_trial = sar_keep;
    if (bit_idx_ff != 4'd0) begin
        nxt_trial[bit_idx_ff + 4'd1] = 1'b1;
    end
end

// Trial code driven to the resistor-string converter; bits 1:0 of the approximation register are dropped.
assign dac_code = sar_ff[11:2];

// Sequencer state, counters and approximation register.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_ff <= ST_IDLE;
        sar_ff <= `SARSEQ_SAR_INIT;
        setup_cnt_ff <= 4'd0;
        step_ff <= 3'd0;
        bit_idx_ff <= 4'd0;
    end else begin
        case (state_ff)
            ST_IDLE: begin
                if (launch) begin
                    state_ff <= ST_SETUP;
                    sar_ff <= `SARSEQ_SAR_INIT;
                    setup_cnt_ff <= 4'd0;
                end
            end
            ST_SETUP: begin
                if (setup_last) begin
                    state_ff <= ST_BITS;
                    bit_idx_ff <= `SARSEQ_RES_BITS - 4'd1;
                    step_ff <= 3'd0;
                end else if (tick) begin
                    setup_cnt_ff <= setup_cnt_ff + 4'd1;
                end
            end
            ST_BITS: begin
                if (step_last) begin
                    sar_ff <= nxt_trial;
                    step_ff <= 3'd0;
                    if (bit_idx_ff == 4'd0) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        bit_idx_ff <= bit_idx_ff - 4'd1;
                    end
                end else if (tick) begin
                    step_ff <= step_ff + 3'd1;
                end
            end
            default: begin
                state_ff <= ST_IDLE;
            end
        endcase
    end
end

// Result pair is replaced by every completed conversion.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        result_ff <= `SARSEQ_RST_RESULT;
    end else if (done) begin
        result_ff <= sar_keep[11:2];
    end
end

// Busy flag lets power control wait for a running conversion to end.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        conv_busy_ff <= 1'b0;
    end else begin
        conv_busy_ff <= (state_ff != ST_IDLE) && !done;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupts.

// Next sticky completion flag, cleared by writing one; a completion in the same cycle wins.
always @* begin
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    if (done) begin
        nxt_irq_stat = 1'b1;
    end else if (wr_stat && hwdata[`SARSEQ_IRQ_DONE]) begin
        nxt_irq_stat = 1'b0;
    end
    if (wr_mask) begin
        nxt_irq_mask = hwdata[`SARSEQ_IRQ_DONE];
    end
end

// Status and mask registers.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        irq_stat_ff <= 1'b0;
        irq_mask_ff <= `SARSEQ_RST_MASK;
    end else begin
        irq_stat_ff <= nxt_irq_stat;
        irq_mask_ff <= nxt_irq_mask;
    end
end

// Level interrupt from the next values, so it is high exactly while an unmasked status bit is set.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        irq_ff <= 1'b0;
    end else begin
        irq_ff <= nxt_irq_stat && nxt_irq_mask;
    end
end

endmodule

// >>> sarseq_consts.vh
`ifndef SARSEQ_CONSTS_VH
`define SARSEQ_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets, decoded on haddr[7:0].
`define SARSEQ_OFF_CTRL 8'hd0
`define SARSEQ_OFF_RES_HIGH 8'hd4
`define SARSEQ_OFF_RES_LOW 8'hd8
`define SARSEQ_OFF_IRQ_STAT 8'hdc
`define SARSEQ_OFF_IRQ_MASK 8'he0
`define SARSEQ_OFF_PORT_ALT 8'he4

////////////////////////////////////////////////////////////////////////////////
// Control register field positions.
`define SARSEQ_CTRL_START 0
`define SARSEQ_CTRL_CLKSEL_LO 1
`define SARSEQ_CTRL_CLKSEL_HI 2
`define SARSEQ_CTRL_EOC 3
`define SARSEQ_CTRL_CHAN_LO 4
`define SARSEQ_CTRL_CHAN_HI 5

// Interrupt status and mask field position.
`define SARSEQ_IRQ_DONE 0

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define SARSEQ_RST_CHAN 2'h0
`define SARSEQ_RST_CLKSEL 2'h0
`define SARSEQ_RST_RESULT 10'h000
`define SARSEQ_RST_PORT_ALT 4'h0
`define SARSEQ_RST_MASK 1'h0

// Mid-scale trial value of the approximation register.
`define SARSEQ_SAR_INIT 12'h800

////////////////////////////////////////////////////////////////////////////////
// Timing counts in conversion clocks, and the result width in bits.
`define SARSEQ_SETUP_CLKS 4'd10
`define SARSEQ_BIT_CLKS 3'd4
`define SARSEQ_RES_BITS 4'd10

// Conversion clock dividers, stored as divide ratio minus one.
`define SARSEQ_DIV_SEL0 8'hff
`define SARSEQ_DIV_SEL1 8'h7f
`define SARSEQ_DIV_SEL2 8'h3f
`define SARSEQ_DIV_SEL3 8'h1f

`endif

// >>> sarseq_clkdiv.v
`include "sarseq_consts.vh"

// Conversion clock generator: one-cycle tick every selected number of cycles.
module sarseq_clkdiv (
    // Clock and reset.
    input wire hclk,
    input wire hresetn,
    // Control.
    input wire [1:0] clksel,
    input wire restart,
    // Conversion clock tick.
    output wire tick
);

reg [7:0] cnt_ff;
reg [7:0] reload;

////////////////////////////////////////////////////////////////////////////////
// Reload value chosen by the clock-select field.
always @* begin
    case (clksel)
        2'h0: reload = `SARSEQ_DIV_SEL0;
        2'h1: reload = `SARSEQ_DIV_SEL1;
        2'h2: reload = `SARSEQ_DIV_SEL2;
        default: reload = `SARSEQ_DIV_SEL3;
    endcase
end

// Down counter; restart aligns the first tick to a full period.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cnt_ff <= 8'h00;
    end else if (restart || cnt_ff == 8'h00) begin
        cnt_ff <= reload;
    end else begin
        cnt_ff <= cnt_ff - 8'h01;
    end
end

// A tick is suppressed in the restart cycle.
assign tick = (cnt_ff == 8'h00) && !restart;

endmodule

// >>> sarseq_chsel.v
`include "sarseq_consts.vh"

// Analog input routing: the selected pin is connected only if its alternate function is on.
module sarseq_chsel (
    // Clock and reset.
    input wire hclk,
    input wire hresetn,
    // Selection.
    input wire [1:0] chan,
    input wire [3:0] port_alt,
    // Analog multiplexer controls.
    output reg [1:0] ain_sel_ff,
    output reg [3:0] ain_connect_ff
);

reg [3:0] nxt_connect;

////////////////////////////////////////////////////////////////////////////////
// One-hot of the channel, gated by the alternate-function enables.
always @* begin
    nxt_connect = (4'h1 << chan) & port_alt;
end

// Registered multiplexer controls.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ain_sel_ff <= `SARSEQ_RST_CHAN;
        ain_connect_ff <= 4'h0;
    end else begin
        ain_sel_ff <= chan;
        ain_connect_ff <= nxt_connect;
    end
end

endmodule

// >>> sarseq_props.sv
module sarseq_props (
    // Clock and reset.
    input wire hclk,
    input wire hresetn,
    // Register bus.
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout_ff,
    // Converter side.
    input wire [9:0] dac_code,
    input wire [1:0] ain_sel,
    input wire [3:0] ain_connect,
    input wire conv_busy_ff,
    input wire irq_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking
        @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Counts the cycles of the running conversion, so its length can be bounded.
    logic [15:0] busy_len_ff;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_len_ff <= 16'h0000;
        end else begin
            busy_len_ff <= conv_busy_ff ? busy_len_ff + 16'h0001 : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // A read data phase holds one wait state, then completes.
    sequence s_read_wait;
        !hreadyout_ff ##1 hreadyout_ff;
    endsequence
    // The mid-scale code is held for eight cycles early in the set-up phase.
    sequence s_setup_code;
        (dac_code == 10'h200) [*8];
    endsequence
    property p_read_wait;
        hsel && htrans[1] && hready && !hwrite |=> s_read_wait;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read data phase has wrong wait states");
    property p_mid_scale;
        $rose(conv_busy_ff) |-> ##2 s_setup_code;
    endproperty
    a_mid_scale: assert property (p_mid_scale) else $error("first trial code is not mid scale");
    property p_length;
        $fell(conv_busy_ff) |-> busy_len_ff >= 16'd1597 && busy_len_ff <= 16'd12803;
    endproperty
    a_length: assert property (p_length) else $error("conversion length out of range");
    property p_idle_after;
        $fell(conv_busy_ff) |-> !conv_busy_ff [*4];
    endproperty
    a_idle_after: assert property (p_idle_after) else $error("sequencer restarted by itself");
    property p_reset_idle;
        $rose(hresetn) |-> !conv_busy_ff [*3];
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("conversion running after reset");
    property p_one_pin;
        ain_connect != 4'h0 |-> ain_connect == (4'h1 << ain_sel);
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("wrong analog pin connected");
    property p_irq_done;
        $rose(irq_ff) |-> !conv_busy_ff;
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("interrupt raised while converting");
    property p_code_quiet;
        $changed(dac_code) |-> ($past(conv_busy_ff) || $past(conv_busy_ff, 2)) or ##[0:2] conv_busy_ff;
    endproperty
    a_code_quiet: assert property (p_code_quiet) else $error("trial code moved while idle");
endmodule

bind sarseq_top sarseq_props u_props (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout_ff(hreadyout_ff),
    .dac_code(dac_code),
    .ain_sel(ain_sel),
    .ain_connect(ain_connect),
    .conv_busy_ff(conv_busy_ff),
    .irq_ff(irq_ff)
);

// >>> sarseq_comp_model.sv
module sarseq_comp_model (
    // Trial code and routing from the sequencer.
    input wire [9:0] dac_code,
    input wire [1:0] ain_sel,
    input wire [3:0] ain_connect,
    // Pin levels in code units, pin 0 in the low bits.
    input wire [39:0] levels,
    // Comparator decision.
    output logic comp_above
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pin that is not connected leaves the comparator input at ground.
    assign comp_above = ain_connect[ain_sel] ? (levels[ain_sel * 10 +: 10] >= dac_code) : 1'b0;
endmodule

// >>> sar_adc_sequencer_tb.sv
module sar_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, comp_above, conv_busy, irq;
    wire [9:0] dac_code;
    wire [1:0] ain_sel;
    wire [3:0] ain_connect;
    logic [9:0] level [4];
    logic [3:0] alt;
    logic mask;
    logic last_busy = 1'b0;
    logic [31:0] rd;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    int busy_cyc = 0;
    int exp_q [$];

    sarseq_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata_ff(hrdata), .hreadyout_ff(hreadyout),
        .hresp_ff(hresp), .comp_above(comp_above), .dac_code(dac_code), .ain_sel(ain_sel),
        .ain_connect(ain_connect), .conv_busy_ff(conv_busy), .irq_ff(irq)
    );
    sarseq_comp_model u_comp (
        .dac_code(dac_code), .ain_sel(ain_sel), .ain_connect(ain_connect),
        .levels({level[3], level[2], level[1], level[0]}), .comp_above(comp_above)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 8 ns.
    always #4 hclk = ~hclk;

    // Cycle limit, and the length of each conversion counted from its first busy cycle.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        last_busy <= conv_busy;
        if (conv_busy === 1'b1) begin
            busy_cyc <= last_busy ? busy_cyc + 1 : 1;
        end
        if (cyc == 40000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compares one value and reports a difference.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single-word transfer; read data lands in rd.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Runs one conversion and checks status, length, result and interrupt against the model.
    task automatic convert(input logic [1:0] ch, input logic [1:0] sel);
        int n;
        int e;
        logic [31:0] ctl;
        ctl = {26'h0, ch, 1'b0, sel, 1'b1};
        exp_q.push_back(alt[ch] ? int'(level[ch]) : 0);
        bus(1'b1, 8'hd0, ctl);
        bus(1'b0, 8'hd0, 32'h0);
        check("ctrl running", ctl, rd);
        check("ain_sel", {30'h0, ch}, {30'h0, ain_sel});
        check("ain_connect", alt[ch] ? 32'h1 << ch : 32'h0, {28'h0, ain_connect});
        n = 0;
        while (conv_busy !== 1'b0 && n < 14000) begin
            @(posedge hclk);
            n++;
        end
        n = 50 * (256 >> sel);
        check("cycles", n, (busy_cyc >= n - 2 && busy_cyc <= n + 2) ? n : busy_cyc);
        bus(1'b0, 8'hd0, 32'h0);
        check("ctrl done", ctl ^ 32'h9, rd);
        e = exp_q.pop_front();
        bus(1'b0, 8'hd4, 32'h0);
        check("result high", e >> 2, rd);
        bus(1'b0, 8'hd8, 32'h0);
        check("result low", e & 3, rd);
        check("irq", {31'h0, mask}, {31'h0, irq});
        bus(1'b0, 8'hdc, 32'h0);
        check("status set", 32'h1, rd);
        check("hresp", 32'h0, {31'h0, hresp});
        bus(1'b1, 8'hdc, 32'h1);
        bus(1'b0, 8'hdc, 32'h0);
        check("status cleared", 32'h0, rd);
        check("irq cleared", 32'h0, {31'h0, irq});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, register checks, every clock select, then a disabled pin.
    initial begin
        void'($urandom(32'h7d45));
        for (int i = 0; i < 4; i++) level[i] = 10'($urandom);
        alt = 4'hf;
        mask = 1'b1;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'hd0, 32'h0);
        check("ctrl reset", 32'h0, rd);
        bus(1'b1, 8'hf0, $urandom);
        bus(1'b0, 8'hf0, 32'h0);
        check("unmapped", 32'h0, rd);
        bus(1'b1, 8'he4, {28'h0, alt});
        bus(1'b1, 8'he0, {31'h0, mask});
        bus(1'b0, 8'he4, 32'h0);
        check("port_alt", {28'h0, alt}, rd);
        for (int c = 0; c < 4; c++) convert(c[1:0], c[1:0]);
        alt = 4'hb;
        mask = 1'b0;
        bus(1'b1, 8'he4, {28'h0, alt});
        bus(1'b1, 8'he0, {31'h0, mask});
        convert(2'h2, 2'h2);
        convert(2'h3, 2'h2);
        // A reset in mid-conversion stops it and leaves the start bit clear.
        bus(1'b1, 8'hd0, 32'h5);
        repeat (100) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("busy after reset", 32'h0, {31'h0, conv_busy});
        bus(1'b0, 8'hd0, 32'h0);
        check("ctrl after reset", 32'h0, rd);
        close_out();
    end
endmodule
